//--- wfs_corr.sv
// Constants for the wake-up and frame sync block, plus one chip correlator.
// Assumes chips arrive as single-cycle strobes on the one baseband clock.
package wfs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LEN_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RSSI_TH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BLK_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BLK_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_WIN_CNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_WPAT_LO = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_WPAT_HI = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LEN_A = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_LEN_B = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PAT_A0 = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_PAT_A1 = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PAT_B0 = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_PAT_B1 = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_GAP = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_TVWIN = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h3C;
  // Control register fields.
  localparam int CTRL_SPM = 0;
  localparam int CTRL_LVL_LSB = 1;
  localparam int CTRL_CRIT_LSB = 3;
  localparam int CTRL_PBIT = 5;
  localparam int CTRL_MODE_LSB = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RSSI_TH_RST = 8'h00;
  // Blocking window starts disabled: high at minimum, low at maximum.
  localparam logic [7:0] BLK_LO_RST = 8'hFF;
  localparam logic [7:0] BLK_HI_RST = 8'h00;
  localparam logic [7:0] WIN_CNT_RST = 8'h11;
  localparam logic [7:0] GAP_RST = 8'h08;
  localparam logic [7:0] TVWIN_RST = 8'h08;
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_RSSI = 2'h1;
  localparam logic [1:0] LVL_SIGREC = 2'h2;
  localparam logic [1:0] CRIT_PATTERN = 2'h0;
  localparam logic [1:0] CRIT_EQUAL = 2'h1;
  localparam logic [1:0] CRIT_RANDOM = 2'h2;
  localparam logic [1:0] CRIT_RATE = 2'h3;
  localparam logic [1:0] MODE_16BIT = 2'h0;
  localparam logic [1:0] MODE_PAR = 2'h1;
  localparam logic [1:0] MODE_EXT = 2'h2;
  localparam logic [1:0] MODE_GAP = 2'h3;
  localparam logic [7:0] WPAT_LEN = 8'h10;
  localparam int SYNC_SEARCH_CYC = 2048;
endpackage

`timescale 1ns/1ps
module wfs_corr
  import wfs_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and control.
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_clear,
  input wire logic i_shift,
  // Chip in, pattern and active length.
  input wire logic i_chip,
  input wire logic [W-1:0] i_pattern,
  input wire logic [LEN_W-1:0] i_len,
  // Match and the oldest chip for chaining.
  output logic o_match,
  output logic o_spill
);
  logic [W-1:0] sh_reg;
  logic [W-1:0] mask;

  // The newest chip sits in bit 0, so pattern bit 0 is the last chip of the identifier.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      mask[i] = (i < int'(i_len));
    end
  end

  assign o_match = (i_len != '0) && (((sh_reg ^ i_pattern) & mask) == '0);
  assign o_spill = sh_reg[W-1];

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sh_reg <= '0;
    end else if (i_ce) begin
      if (i_clear) begin
        sh_reg <= '0;
      end else if (i_shift) begin
        sh_reg <= {sh_reg[W-2:0], i_chip};
      end
    end
  end
endmodule

//--- wfs_top.sv
// Wake-up decision and frame start search for the receive baseband.
// Assumes chip, bit, sync and level inputs are synchronous to i_ref_clk.
`timescale 1ns/1ps
module wfs_top
  import wfs_pkg::*;
#(
  parameter int SYNC_CYC = SYNC_SEARCH_CYC
) (
  // Clock, reset, enable.
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Register port.
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Recovered stream.
  input wire logic i_chip_vld,
  input wire logic i_chip,
  input wire logic i_bit_vld,
  input wire logic i_bit,
  input wire logic i_sym_sync,
  // Level detectors and polling control.
  input wire logic [7:0] i_rssi,
  input wire logic i_rssi_vld,
  input wire logic i_sigrec,
  input wire logic i_t16_stb,
  input wire logic i_poll_start,
  // Events.
  output logic o_wakeup,
  output logic o_frame_sync_pulse,
  output logic o_frame_sync_pulse_b,
  output logic o_id_bit_vld,
  output logic o_id_bit,
  output logic o_cv
);
  typedef enum logic [1:0] {W_IDLE, W_SYNC, W_SEARCH} wfs_wake_e;
  typedef enum logic [1:0] {F_IDLE, F_HUNT, F_GAP, F_HUNTB} wfs_frame_e;

  wfs_wake_e wstate_reg, wstate_next;
  wfs_frame_e fstate_reg, fstate_next;
  logic [7:0] ctrl_reg, rssi_th_reg, blk_lo_reg, blk_hi_reg, win_cnt_reg;
  logic [7:0] wpat_lo_reg, wpat_hi_reg, gap_reg, tvwin_reg;
  logic [LEN_W-1:0] len_a_reg, len_b_reg;
  logic [7:0] pat_a0_reg, pat_a1_reg, pat_b0_reg, pat_b1_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [$clog2(SYNC_CYC+1)-1:0] sync_tmr_reg;
  logic [7:0] unit_cnt_reg, sr_cnt_reg, fcnt_reg;
  logic [15:0] wsh_reg;
  logic first_bit_reg, last_chip_reg, sync_d_reg, chk_reg;
  logic [1:0] run_reg;
  logic wake_reg, frame_sync_pulse_reg, frame_sync_pulse_b_reg, id_vld_reg, id_bit_reg, cv_reg;

  // Decoded control fields.
  wire self_polling_mode = ctrl_reg[CTRL_SPM];
  wire [1:0] lvl_sel = ctrl_reg[CTRL_LVL_LSB +: 2];
  wire [1:0] crit = ctrl_reg[CTRL_CRIT_LSB +: 2];
  wire pbit = ctrl_reg[CTRL_PBIT];
  wire [1:0] mode = ctrl_reg[CTRL_MODE_LSB +: 2];

  // Register writes.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ctrl_reg <= CTRL_RST;
      rssi_th_reg <= RSSI_TH_RST;
      blk_lo_reg <= BLK_LO_RST;
      blk_hi_reg <= BLK_HI_RST;
      win_cnt_reg <= WIN_CNT_RST;
      wpat_lo_reg <= 8'h00;
      wpat_hi_reg <= 8'h00;
      len_a_reg <= '0;
      len_b_reg <= '0;
      pat_a0_reg <= 8'h00;
      pat_a1_reg <= 8'h00;
      pat_b0_reg <= 8'h00;
      pat_b1_reg <= 8'h00;
      gap_reg <= GAP_RST;
      tvwin_reg <= TVWIN_RST;
    end else if (i_ce && i_wr) begin
      unique case (i_addr)
        OFS_CTRL: ctrl_reg <= i_wdata[7:0];
        OFS_RSSI_TH: rssi_th_reg <= i_wdata[7:0];
        OFS_BLK_LO: blk_lo_reg <= i_wdata[7:0];
        OFS_BLK_HI: blk_hi_reg <= i_wdata[7:0];
        OFS_WIN_CNT: win_cnt_reg <= i_wdata[7:0];
        OFS_WPAT_LO: wpat_lo_reg <= i_wdata[7:0];
        OFS_WPAT_HI: wpat_hi_reg <= i_wdata[7:0];
        OFS_LEN_A: len_a_reg <= i_wdata[LEN_W-1:0];
        OFS_LEN_B: len_b_reg <= i_wdata[LEN_W-1:0];
        OFS_PAT_A0: pat_a0_reg <= i_wdata[7:0];
        OFS_PAT_A1: pat_a1_reg <= i_wdata[7:0];
        OFS_PAT_B0: pat_b0_reg <= i_wdata[7:0];
        OFS_PAT_B1: pat_b1_reg <= i_wdata[7:0];
        OFS_GAP: gap_reg <= i_wdata[7:0];
        OFS_TVWIN: tvwin_reg <= i_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Read selection; unmapped addresses read as zero.
  logic [DATA_W-1:0] rsel;
  always_comb begin
    unique case (i_addr)
      OFS_CTRL: rsel = {24'h000000, ctrl_reg};
      OFS_RSSI_TH: rsel = {24'h000000, rssi_th_reg};
      OFS_BLK_LO: rsel = {24'h000000, blk_lo_reg};
      OFS_BLK_HI: rsel = {24'h000000, blk_hi_reg};
      OFS_WIN_CNT: rsel = {24'h000000, win_cnt_reg};
      OFS_WPAT_LO: rsel = {24'h000000, wpat_lo_reg};
      OFS_WPAT_HI: rsel = {24'h000000, wpat_hi_reg};
      OFS_LEN_A: rsel = {27'h0000000, len_a_reg};
      OFS_LEN_B: rsel = {27'h0000000, len_b_reg};
      OFS_PAT_A0: rsel = {24'h000000, pat_a0_reg};
      OFS_PAT_A1: rsel = {24'h000000, pat_a1_reg};
      OFS_PAT_B0: rsel = {24'h000000, pat_b0_reg};
      OFS_PAT_B1: rsel = {24'h000000, pat_b1_reg};
      OFS_GAP: rsel = {24'h000000, gap_reg};
      OFS_TVWIN: rsel = {24'h000000, tvwin_reg};
      OFS_STATUS: rsel = {24'h000000, unit_cnt_reg[3:0], fstate_reg, wstate_reg};
      default: rsel = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rdata_reg <= 32'h00000000;
    end else if (i_ce) begin
      rdata_reg <= i_rd ? rsel : 32'h00000000;
    end
  end

  // Code violation: a third chip equal to the previous two.
  wire same_chip = (i_chip == last_chip_reg);
  wire cv_now = i_chip_vld && same_chip && (run_reg >= 2'h2);

  // Level criteria.
  wire in_block = (i_rssi >= blk_lo_reg) && (i_rssi <= blk_hi_reg);
  wire rssi_ok = i_rssi_vld && (i_rssi > rssi_th_reg) && !in_block;
  wire [8:0] sr_cnt_inc = {1'b0, sr_cnt_reg} + 9'h001;
  wire sr_hit = i_t16_stb && i_sigrec && (sr_cnt_inc >= {1'b0, blk_hi_reg});
  wire observing = (wstate_reg != W_IDLE);
  wire level_hit = observing &&
    (((lvl_sel == LVL_RSSI) && rssi_ok) || ((lvl_sel == LVL_SIGREC) && sr_hit));

  // Data criteria: one of four, selected by crit.
  wire chip_units = (crit == CRIT_PATTERN) && !pbit;
  wire unit_stb = chip_units ? i_chip_vld : i_bit_vld;
  wire [8:0] unit_inc = {1'b0, unit_cnt_reg} + 9'h001;
  wire win_done = unit_stb && (unit_inc >= {1'b0, win_cnt_reg});
  wire [15:0] wsh_next = {wsh_reg[14:0], (pbit ? i_bit : i_chip)};
  wire pat_hit = (crit == CRIT_PATTERN) && unit_stb && (unit_inc >= {1'b0, WPAT_LEN}) &&
    (wsh_next == {wpat_hi_reg, wpat_lo_reg});
  wire eq_break = (crit == CRIT_EQUAL) && i_bit_vld && (unit_cnt_reg != 8'h00) &&
    (i_bit != first_bit_reg);
  wire cv_abort = cv_now && ((crit == CRIT_EQUAL) || (crit == CRIT_RANDOM) ||
    ((crit == CRIT_PATTERN) && pbit));
  wire searching = (wstate_reg == W_SEARCH);
  wire count_hit = ((crit == CRIT_EQUAL) || (crit == CRIT_RANDOM)) && win_done;
  wire data_hit = searching && i_sym_sync && !cv_abort && !eq_break &&
    (pat_hit || count_hit);
  wire rate_hit = (wstate_reg == W_SYNC) && i_sym_sync && (crit == CRIT_RATE);
  wire wake_evt = level_hit || data_hit || rate_hit;
  wire sync_timeout = (wstate_reg == W_SYNC) && (int'(sync_tmr_reg) >= SYNC_CYC - 1);

  always_comb begin
    wstate_next = wstate_reg;
    unique case (wstate_reg)
      W_IDLE: begin
        if (i_poll_start) begin
          wstate_next = W_SYNC;
        end
      end
      W_SYNC: begin
        if (wake_evt || sync_timeout) begin
          wstate_next = W_IDLE;
        end else if (i_sym_sync) begin
          wstate_next = W_SEARCH;
        end
      end
      W_SEARCH: begin
        if (wake_evt || !i_sym_sync || cv_abort || eq_break || win_done) begin
          wstate_next = W_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wstate_reg <= W_IDLE;
      sync_tmr_reg <= '0;
      unit_cnt_reg <= 8'h00;
      sr_cnt_reg <= 8'h00;
      wsh_reg <= 16'h0000;
      first_bit_reg <= 1'b0;
      last_chip_reg <= 1'b0;
      run_reg <= 2'h0;
      wake_reg <= 1'b0;
      cv_reg <= 1'b0;
    end else if (i_ce) begin
      wstate_reg <= wstate_next;
      wake_reg <= wake_evt;
      cv_reg <= cv_now;
      sync_tmr_reg <= (wstate_reg == W_SYNC) ? sync_tmr_reg + 1'b1 : '0;
      if (i_chip_vld) begin
        last_chip_reg <= i_chip;
        run_reg <= (same_chip && run_reg != 2'h0) ? ((run_reg == 2'h3) ? 2'h3 : run_reg + 2'h1)
          : 2'h1;
      end
      if (i_t16_stb) begin
        sr_cnt_reg <= !i_sigrec ? 8'h00 : (sr_cnt_inc[8] ? 8'hFF : sr_cnt_inc[7:0]);
      end
      if (!searching) begin
        unit_cnt_reg <= 8'h00;
        wsh_reg <= 16'h0000;
      end else if (unit_stb) begin
        unit_cnt_reg <= unit_inc[7:0];
        wsh_reg <= wsh_next;
        if (unit_cnt_reg == 8'h00) begin
          first_bit_reg <= i_bit;
        end
      end
    end
  end

  // Frame synchronizer.
  wire sync_rise = i_sym_sync && !sync_d_reg;
  wire frame_go = self_polling_mode ? wake_reg : sync_rise;
  wire hunting = (fstate_reg != F_IDLE);
  wire corr_shift = hunting && i_chip_vld;
  wire clr_a = (fstate_reg == F_IDLE);
  wire clr_b = clr_a || ((fstate_reg == F_GAP) && (fcnt_reg >= gap_reg));
  wire chain = (mode == MODE_16BIT);
  wire match_a, match_b, spill_a;

  wfs_corr #(.W(16)) u_corr_a (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_clear(clr_a),
    .i_shift(corr_shift),
    .i_chip(i_chip),
    .i_pattern({pat_a1_reg, pat_a0_reg}),
    .i_len(len_a_reg),
    .o_match(match_a),
    .o_spill(spill_a)
  );

  // In 16-bit mode B holds the older chips shifted out of A.
  wfs_corr #(.W(16)) u_corr_b (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_clear(clr_b),
    .i_shift(corr_shift),
    .i_chip(chain ? spill_a : i_chip),
    .i_pattern({pat_b1_reg, pat_b0_reg}),
    .i_len(len_b_reg),
    .o_match(match_b),
    .o_spill()
  );

  // Matches are judged one cycle after the shift; A wins a tie in parallel modes.
  wire hit_chain = chk_reg && match_a && ((len_b_reg == '0) || match_b);
  wire hit_a = chk_reg && match_a;
  wire hit_b = chk_reg && match_b && !match_a;
  wire in_hunt = (fstate_reg == F_HUNT);
  wire found_a = in_hunt && (chain ? hit_chain : ((mode != MODE_GAP) && hit_a));
  wire found_b = ((in_hunt && (mode == MODE_PAR || mode == MODE_EXT)) ||
    (fstate_reg == F_HUNTB)) && chk_reg && match_b;
  wire frame_sync_pulse_evt = i_sym_sync && (found_a || found_b);

  always_comb begin
    fstate_next = fstate_reg;
    unique case (fstate_reg)
      F_IDLE: begin
        if (frame_go) begin
          fstate_next = F_HUNT;
        end
      end
      F_HUNT: begin
        if (!i_sym_sync || frame_sync_pulse_evt) begin
          fstate_next = F_IDLE;
        end else if ((mode == MODE_GAP) && hit_a) begin
          fstate_next = F_GAP;
        end
      end
      F_GAP: begin
        if (!i_sym_sync) begin
          fstate_next = F_IDLE;
        end else if (fcnt_reg >= gap_reg) begin
          fstate_next = F_HUNTB;
        end
      end
      F_HUNTB: begin
        if (!i_sym_sync || frame_sync_pulse_evt) begin
          fstate_next = F_IDLE;
        end else if (fcnt_reg >= tvwin_reg) begin
          fstate_next = F_HUNT;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      fstate_reg <= F_IDLE;
      fcnt_reg <= 8'h00;
      sync_d_reg <= 1'b0;
      chk_reg <= 1'b0;
      frame_sync_pulse_reg <= 1'b0;
      frame_sync_pulse_b_reg <= 1'b0;
      id_vld_reg <= 1'b0;
      id_bit_reg <= 1'b0;
    end else if (i_ce) begin
      fstate_reg <= fstate_next;
      sync_d_reg <= i_sym_sync;
      chk_reg <= corr_shift;
      frame_sync_pulse_reg <= frame_sync_pulse_evt;
      frame_sync_pulse_b_reg <= frame_sync_pulse_evt && !found_a;
      id_vld_reg <= frame_sync_pulse_evt && (mode == MODE_EXT);
      id_bit_reg <= frame_sync_pulse_evt && (mode == MODE_EXT) && !found_a;
      if (fstate_next != fstate_reg) begin
        fcnt_reg <= 8'h00;
      end else if (corr_shift && fcnt_reg != 8'hFF) begin
        fcnt_reg <= fcnt_reg + 8'h01;
      end
    end
  end

  assign o_rdata = rdata_reg;
  assign o_wakeup = wake_reg;
  assign o_frame_sync_pulse = frame_sync_pulse_reg;
  assign o_frame_sync_pulse_b = frame_sync_pulse_b_reg;
  assign o_id_bit_vld = id_vld_reg;
  assign o_id_bit = id_bit_reg;
  assign o_cv = cv_reg;

  rssi_wake_a:
  assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_ce && observing && lvl_sel == LVL_RSSI && i_rssi_vld && i_rssi > rssi_th_reg &&
     !in_block) |=> o_wakeup)
  else $error("RSSI above threshold gave no wake-up");

  rssi_block_a:
  assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_ce && wstate_reg == W_SYNC && lvl_sel == LVL_RSSI && crit != CRIT_RATE &&
     i_rssi_vld && in_block) |=> !o_wakeup)
  else $error("Blocked RSSI level woke the receiver");

  sync_abort_a:
  assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_ce && searching && !i_sym_sync) |=> (wstate_reg == W_IDLE) && !o_wakeup)
  else $error("Search not aborted on sync loss");

  window_stop_a:
  assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_ce && searching && win_done) |=> wstate_reg == W_IDLE)
  else $error("Search outlived the wake window");

  cv_flag_a:
  assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_ce && i_chip_vld && run_reg == 2'h2 && i_chip == last_chip_reg) |=> o_cv)
  else $error("Third equal chip not flagged");

  wake_pulse_a:
  assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $past(i_ce) && o_wakeup |-> $past(wstate_reg) != W_IDLE)
  else $error("Wake-up pulse outside an observation");

  frame_loss_a:
  assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_ce && hunting && !i_sym_sync) |=> fstate_reg == F_IDLE ##1 !o_frame_sync_pulse)
  else $error("Framer kept searching after sync loss");

  ext_bit_a:
  assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_id_bit_vld |-> o_frame_sync_pulse && (o_id_bit == o_frame_sync_pulse_b))
  else $error("Inserted bit does not name the matching correlator");

  frame_sync_pulse_once_a:
  assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_frame_sync_pulse |-> ##1 !o_frame_sync_pulse)
  else $error("Frame sync longer than one cycle");
endmodule

//--- wfs_src.sv
// Behavioural source of the recovered chip stream, decoded bits and symbol sync.
// Assumes the bench calls its tasks from one process clocked by i_ref_clk.
`timescale 1ns/1ps
module wfs_src (
  // Clock.
  input wire logic i_ref_clk,
  // Stream towards the block.
  output logic o_chip_vld,
  output logic o_chip,
  output logic o_bit_vld,
  output logic o_bit,
  output logic o_sym_sync
);
  initial begin
    o_chip_vld = 1'b0;
    o_chip = 1'b0;
    o_bit_vld = 1'b0;
    o_bit = 1'b0;
    o_sym_sync = 1'b0;
  end

  task automatic set_sync(input logic v);
    @(posedge i_ref_clk);
    o_sym_sync <= v;
  endtask

  // Chips leave oldest first, one every four cycles; a bit follows each chip pair and
  // takes the first chip of the pair. Between chips the lines show the inverse of the
  // last value, so a block that samples outside the strobe sees wrong data.
  task automatic send(input logic [39:0] chips, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      repeat (3) @(posedge i_ref_clk);
      o_chip_vld <= 1'b1;
      o_chip <= chips[i];
      o_bit_vld <= (i % 2 == 0);
      o_bit <= chips[i | 1];
      @(posedge i_ref_clk);
      o_chip_vld <= 1'b0;
      o_bit_vld <= 1'b0;
      o_chip <= ~chips[i];
      o_bit <= ~chips[i | 1];
    end
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the wake-up and frame sync block.
// Assumes the stream source model drives the chip, bit and sync inputs.
`timescale 1ns/1ps
module tb_top;
  import wfs_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_rssi = 8'h00;
  logic i_rssi_vld = 1'b0;
  logic i_sigrec = 1'b0;
  logic i_t16_stb = 1'b0;
  logic i_poll_start = 1'b0;
  logic i_ce = 1'b1;
  localparam int P_POLL = 0;
  localparam int P_RSSI = 1;
  localparam int P_T16 = 2;
  logic [DATA_W-1:0] o_rdata;
  logic chip_vld, chip, bit_vld, bit_val, sym_sync;
  logic o_wakeup, o_frame_sync_pulse, o_frame_sync_pulse_b, o_id_bit_vld, o_id_bit, o_cv;
  logic fs_b, id_vld, id_bit;
  int n_errors = 0;
  int checks_done = 0;
  int n_wake = 0;
  int n_fs = 0;
  int n_cv = 0;

  always #4 i_ref_clk = ~i_ref_clk;

  wfs_src src (.i_ref_clk(i_ref_clk), .o_chip_vld(chip_vld), .o_chip(chip),
    .o_bit_vld(bit_vld), .o_bit(bit_val), .o_sym_sync(sym_sync));

  // A short sync search keeps each observation brief in simulation.
  wfs_top #(.SYNC_CYC(64)) DUT (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_chip_vld(chip_vld), .i_chip(chip), .i_bit_vld(bit_vld), .i_bit(bit_val),
    .i_sym_sync(sym_sync), .i_rssi(i_rssi), .i_rssi_vld(i_rssi_vld), .i_sigrec(i_sigrec),
    .i_t16_stb(i_t16_stb), .i_poll_start(i_poll_start), .o_wakeup(o_wakeup),
    .o_frame_sync_pulse(o_frame_sync_pulse), .o_frame_sync_pulse_b(o_frame_sync_pulse_b), .o_id_bit_vld(o_id_bit_vld),
    .o_id_bit(o_id_bit), .o_cv(o_cv));

  always @(posedge i_ref_clk) begin
    if (o_wakeup === 1'b1) n_wake++;
    if (o_cv === 1'b1) n_cv++;
    if (o_frame_sync_pulse === 1'b1) begin
      n_fs++;
      fs_b = o_frame_sync_pulse_b;
      id_vld = o_id_bit_vld;
      id_bit = o_id_bit;
    end
  end

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #(60000 * 8);
    n_errors++;
    end_sim();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // One-cycle strobe on the polling start, RSSI valid or T/16 line.
  task automatic pulse(input int w);
    @(posedge i_ref_clk);
    if (w == P_POLL) i_poll_start <= 1'b1;
    else if (w == P_RSSI) i_rssi_vld <= 1'b1;
    else i_t16_stb <= 1'b1;
    @(posedge i_ref_clk);
    i_poll_start <= 1'b0;
    i_rssi_vld <= 1'b0;
    i_t16_stb <= 1'b0;
  endtask

  task automatic rs(input logic [7:0] v);
    i_rssi <= v;
    pulse(P_RSSI);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] md, input logic [1:0] cr,
                                      input logic [1:0] lv, input logic sp);
    return {24'h0, md, 1'b0, cr, lv, sp};
  endfunction

  task automatic t_regs;
    logic [DATA_W-1:0] d;
    logic [ADDR_W-1:0] a[8] = '{OFS_CTRL, OFS_RSSI_TH, OFS_BLK_LO, OFS_BLK_HI,
                                OFS_WIN_CNT, OFS_GAP, OFS_TVWIN, 8'h40};
    logic [7:0] e[8] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h11, 8'h08, 8'h08, 8'h00};
    // A write while the enable is low must not land; the gap read below proves it.
    i_ce <= 1'b0;
    wr(OFS_GAP, 32'h0000_0033);
    i_ce <= 1'b1;
    wr(8'h40, 32'h0000_00FF);
    for (int i = 0; i < 8; i++) begin
      rd(a[i], d);
      chk(d, {24'h0, e[i]});
    end
  endtask

  task automatic t_rssi;
    wr(OFS_RSSI_TH, 32'h40);
    wr(OFS_BLK_LO, 32'h60);
    wr(OFS_BLK_HI, 32'h70);
    wr(OFS_CTRL, ctl(MODE_16BIT, CRIT_PATTERN, LVL_RSSI, 1'b1));
    n_wake = 0;
    pulse(P_POLL);
    rs(8'h65);
    rs(8'h60);
    rs(8'h70);
    rs(8'h40);
    repeat (3) @(posedge i_ref_clk);
    chk(n_wake, 0);
    rs(8'h71);
    repeat (3) @(posedge i_ref_clk);
    chk(n_wake, 1);
    wr(OFS_BLK_LO, 32'hFF);
    wr(OFS_BLK_HI, 32'h00);
    pulse(P_POLL);
    rs(8'h65);
    repeat (3) @(posedge i_ref_clk);
    chk(n_wake, 2);
  endtask

  task automatic t_sigrec;
    logic [7:0] s = 8'hEF;
    wr(OFS_BLK_HI, 32'h04);
    wr(OFS_CTRL, ctl(MODE_16BIT, CRIT_PATTERN, LVL_SIGREC, 1'b1));
    n_wake = 0;
    // All samples fall well inside the observation opened here.
    pulse(P_POLL);
    for (int i = 7; i >= 0; i--) begin
      if (i == 0) chk(n_wake, 0);
      i_sigrec <= s[i];
      pulse(P_T16);
    end
    repeat (3) @(posedge i_ref_clk);
    chk(n_wake, 1);
  endtask

  task automatic t_wake;
    logic [1:0] cr[7] = '{CRIT_PATTERN, CRIT_PATTERN, CRIT_EQUAL, CRIT_EQUAL,
                          CRIT_RANDOM, CRIT_RANDOM, CRIT_RATE};
    logic [39:0] st[7] = '{40'h9669AAAAAA, 40'hAAAAAA9669, 40'hAAAAAAAAAA,
                           40'hAAAA6AAAAA, 40'h9669966996, 40'h96E9966996, 40'h9669966996};
    logic ew[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic ec[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    wr(OFS_WIN_CNT, 32'h11);
    wr(OFS_WPAT_LO, 32'h69);
    wr(OFS_WPAT_HI, 32'h96);
    // Sync arriving after the search time must not wake, even on the rate criterion.
    wr(OFS_CTRL, ctl(MODE_16BIT, CRIT_RATE, LVL_NONE, 1'b1));
    n_wake = 0;
    pulse(P_POLL);
    repeat (70) @(posedge i_ref_clk);
    src.set_sync(1'b1);
    repeat (4) @(posedge i_ref_clk);
    chk(n_wake, 0);
    for (int i = 0; i < 7; i++) begin
      wr(OFS_CTRL, ctl(MODE_16BIT, cr[i], LVL_NONE, 1'b1));
      src.set_sync(1'b0);
      pulse(P_POLL);
      n_wake = 0;
      n_cv = 0;
      src.set_sync(1'b1);
      src.send(st[i], 40);
      repeat (8) @(posedge i_ref_clk);
      chk(n_wake, ew[i]);
      chk(n_cv != 0, ec[i]);
    end
    src.set_sync(1'b0);
  endtask

  task automatic t_frame;
    logic [1:0] md[5] = '{MODE_EXT, MODE_EXT, MODE_PAR, MODE_16BIT, MODE_GAP};
    logic [39:0] fs[5] = '{40'h555A, 40'h5555F00F, 40'h555A, 40'h5AF00F, 40'hF00F005A};
    int nn[5] = '{16, 32, 16, 24, 32};
    logic eb[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic ev[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    wr(OFS_LEN_A, 32'd16);
    wr(OFS_LEN_B, 32'd8);
    wr(OFS_PAT_A0, 32'h0F);
    wr(OFS_PAT_A1, 32'hF0);
    wr(OFS_PAT_B0, 32'h5A);
    wr(OFS_TVWIN, 32'h10);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL, ctl(md[i], CRIT_PATTERN, LVL_NONE, 1'b0));
      src.set_sync(1'b0);
      src.set_sync(1'b1);
      n_fs = 0;
      id_vld = 1'b0;
      src.send(fs[i], nn[i]);
      repeat (6) @(posedge i_ref_clk);
      chk(n_fs, 1);
      chk(id_vld, ev[i]);
      if (i < 4) chk(fs_b, eb[i]);
      if (ev[i]) chk(id_bit, eb[i]);
    end
    src.set_sync(1'b0);
  endtask

  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    t_regs();
    t_rssi();
    t_sigrec();
    t_wake();
    t_frame();
    end_sim();
  end
endmodule
